// file: include/pio_map.vh
// Overview of operation
// - twenty programmable pins form four ports, each pin individually input or output
// - direction bit one enables the pin output buffer, zero disables it
// - reset clears every implemented direction bit so all pins are inputs
// - reset leaves all four data latches unchanged
// - data latches of ports a to d sit at addresses zero to three
// - output pins read back the stored latch value, not the pin
// - input pins read back the sampled pin level
// - writes always update the output latch regardless of direction
// - port a has eight pins and an eight-bit direction register at address four
// - port b implements only bits seven to five in data and direction
// - port logic runs from the oscillator clock divided by two
// - active-low reset pin forces port logic to its start-up state
// - port b pins are general purpose while the serial port is disabled
`ifndef PIO_MAP_VH
`define PIO_MAP_VH
// ----------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------
`define PIO_IDX_A_DATA 8'h00
`define PIO_IDX_B_DATA 8'h01
`define PIO_IDX_C_DATA 8'h02
`define PIO_IDX_D_DATA 8'h03
`define PIO_IDX_A_DIR 8'h04
`define PIO_IDX_B_DIR 8'h05
`define PIO_IDX_C_DIR 8'h06
`define PIO_IDX_D_DIR 8'h07
`define PIO_IDX_CTRL 8'h08
// ----------------------------------------
// implemented bit masks and reset values
// ----------------------------------------
`define PIO_MASK_A 8'hff
`define PIO_MASK_B 8'he0
`define PIO_MASK_C 8'hff
`define PIO_MASK_D_DIR 8'h20
`define PIO_MASK_D_DATA 8'ha0
`define PIO_DIR_RESET 8'h00
`define PIO_CTRL_SERIAL_EN_BIT 0
`define PIO_CLK_DIV 2
`endif

// file: hdl/pio_port.v
`timescale 1ns/10ps
`default_nettype none
`include "pio_map.vh"
// one port: latch, direction, pin drive and read mux
module pio_port #(
  parameter [7:0] DATA_MASK = 8'hff,
  parameter [7:0] DIR_MASK = 8'hff
) (
  input wire clk, // system clock
  input wire srst, // synchronous reset
  input wire op_en, // internal operating enable
  input wire rst_req, // port reset request
  input wire data_we, // write data latch
  input wire dir_we, // write direction
  input wire [7:0] wdata, // write data
  input wire [7:0] pin_in, // pin levels
  input wire [7:0] force_in, // force bits to input
  output wire [7:0] pin_out, // pin drive values
  output wire [7:0] pin_oe, // pin output enables
  output reg [7:0] rdata_port, // data latch read value
  output wire [7:0] rdata_dir // direction read value
);
  reg [7:0] latch;
  reg [7:0] dir;
  reg [7:0] pin_smp;
  wire [7:0] dir_eff;
  integer i;
  // ----------------------------------------
  // storage
  // ----------------------------------------
  always @(posedge clk) begin
    if (op_en && data_we) begin
      latch <= wdata & DATA_MASK;
    end
  end
  always @(posedge clk) begin
    if (srst || rst_req) begin
      dir <= `PIO_DIR_RESET;
    end else if (op_en && dir_we) begin
      dir <= wdata & DIR_MASK;
    end
  end
  always @(posedge clk) begin
    if (op_en) begin
      pin_smp <= pin_in & DATA_MASK;
    end
  end
  // ----------------------------------------
  // pin drive and read mux
  // ----------------------------------------
  assign dir_eff = dir & ~force_in & DIR_MASK;
  assign pin_oe = dir_eff;
  assign pin_out = latch & DIR_MASK;
  assign rdata_dir = dir;
  always @* begin
    rdata_port = 8'h00;
    for (i = 0; i < 8; i = i + 1) begin
      if (dir_eff[i]) begin
        rdata_port[i] = latch[i];
      end else begin
        rdata_port[i] = pin_smp[i] & DATA_MASK[i];
      end
    end
  end
endmodule
`default_nettype wire

// file: hdl/pio_top.v
// Decided for this implementation: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "pio_map.vh"
// four parallel ports behind an apb slave
module pio_top (
  input wire clk, // system clock, oscillator rate
  input wire srst, // synchronous reset
  input wire reset_n, // active-low device reset pin
  input wire psel, // apb select
  input wire penable, // apb enable
  input wire pwrite, // apb direction
  input wire [11:0] paddr, // apb byte address
  input wire [31:0] pwdata, // apb write data
  output wire pready, // apb ready
  output reg [31:0] prdata, // apb read data
  output wire pslverr, // apb error
  input wire [7:0] port_a_pins_in, // port a pin levels
  output wire [7:0] port_a_pins_out, // port a drive
  output wire [7:0] port_a_pins_oe, // port a enables
  input wire [7:0] port_b_pins_in, // port b pin levels
  output wire [7:0] port_b_pins_out, // port b drive
  output wire [7:0] port_b_pins_oe, // port b enables
  input wire [7:0] port_c_pins_in, // port c pin levels
  output wire [7:0] port_c_pins_out, // port c drive
  output wire [7:0] port_c_pins_oe, // port c enables
  input wire [7:0] port_d_pins_in, // port d pin levels
  output wire [7:0] port_d_pins_out, // port d drive
  output wire [7:0] port_d_pins_oe, // port d enables
  output wire serial_port_en // serial port enable state
);
  // ----------------------------------------
  // internal operating enable, clock divided by two
  // ----------------------------------------
  reg op_en;
  always @(posedge clk) begin
    if (srst) begin
      op_en <= 1'b0;
    end else begin
      op_en <= ~op_en;
    end
  end
  // ----------------------------------------
  // apb decode; access waits for the operating enable
  // ----------------------------------------
  wire access = psel && penable && op_en;
  wire [7:0] idx = paddr[9:2];
  wire aligned = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
  reg [3:0] data_we;
  reg [3:0] dir_we;
  reg ctrl_we;
  reg hit;
  reg ctrl_serial;
  wire rst_req = ~reset_n;
  always @* begin
    data_we = 4'h0;
    dir_we = 4'h0;
    ctrl_we = 1'b0;
    hit = 1'b1;
    if (!aligned) begin
      hit = 1'b0;
    end else if (idx <= `PIO_IDX_D_DATA) begin
      data_we[idx[1:0]] = access && pwrite;
    end else if (idx <= `PIO_IDX_D_DIR) begin
      dir_we[idx[1:0]] = access && pwrite;
    end else if (idx == `PIO_IDX_CTRL) begin
      ctrl_we = access && pwrite;
    end else begin
      hit = 1'b0;
    end
  end
  assign pready = op_en;
  assign pslverr = psel && penable && !hit;
  always @(posedge clk) begin
    if (srst || rst_req) begin
      ctrl_serial <= 1'b0;
    end else if (ctrl_we) begin
      ctrl_serial <= pwdata[`PIO_CTRL_SERIAL_EN_BIT];
    end
  end
  assign serial_port_en = ctrl_serial;
  // ----------------------------------------
  // ports, one generate per port
  // ----------------------------------------
  wire [31:0] pin_in_all = {port_d_pins_in, port_c_pins_in, port_b_pins_in, port_a_pins_in};
  wire [31:0] pin_out_all;
  wire [31:0] pin_oe_all;
  wire [31:0] rd_port_all;
  wire [31:0] rd_dir_all;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gen_port
      localparam [7:0] DMASK = (g == 0) ? `PIO_MASK_A : (g == 1) ? `PIO_MASK_B :
        (g == 2) ? `PIO_MASK_C : `PIO_MASK_D_DATA;
      localparam [7:0] RMASK = (g == 0) ? `PIO_MASK_A : (g == 1) ? `PIO_MASK_B :
        (g == 2) ? `PIO_MASK_C : `PIO_MASK_D_DIR;
      pio_port #(
        .DATA_MASK(DMASK),
        .DIR_MASK(RMASK)
      ) u_port (
        .clk(clk),
        .srst(srst),
        .op_en(op_en),
        .rst_req(rst_req),
        .data_we(data_we[g]),
        .dir_we(dir_we[g]),
        .wdata(pwdata[7:0]),
        .pin_in(pin_in_all[g*8 +: 8]),
        .force_in(8'h00),
        .pin_out(pin_out_all[g*8 +: 8]),
        .pin_oe(pin_oe_all[g*8 +: 8]),
        .rdata_port(rd_port_all[g*8 +: 8]),
        .rdata_dir(rd_dir_all[g*8 +: 8])
      );
    end
  endgenerate
  // port b stays general purpose; the serial port takeover is not built here
  assign port_a_pins_out = pin_out_all[7:0];
  assign port_a_pins_oe = pin_oe_all[7:0];
  assign port_b_pins_out = pin_out_all[15:8];
  assign port_b_pins_oe = pin_oe_all[15:8];
  assign port_c_pins_out = pin_out_all[23:16];
  assign port_c_pins_oe = pin_oe_all[23:16];
  assign port_d_pins_out = pin_out_all[31:24];
  assign port_d_pins_oe = pin_oe_all[31:24];
  // ----------------------------------------
  // read data register
  // ----------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= 32'h00000000;
      if (!aligned) begin
        prdata <= 32'h00000000;
      end else if (idx <= `PIO_IDX_D_DATA) begin
        prdata <= {24'h000000, rd_port_all[idx[1:0]*8 +: 8]};
      end else if (idx <= `PIO_IDX_D_DIR) begin
        prdata <= {24'h000000, rd_dir_all[idx[1:0]*8 +: 8]};
      end else if (idx == `PIO_IDX_CTRL) begin
        prdata <= {31'h0, ctrl_serial};
      end
    end
  end
endmodule
`default_nettype wire

// file: testbench/pio_chk.sv
`timescale 1ns/10ps
`default_nettype none
module pio_chk (
  input wire logic clk, // clock
  input wire logic srst, // sync reset
  input wire logic reset_n, // device reset pin
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic pready, // apb ready
  input wire logic [31:0] prdata, // apb read data
  input wire logic [7:0] port_a_pins_out, // port a drive
  input wire logic [7:0] port_a_pins_oe, // port a enables
  input wire logic [7:0] port_b_pins_oe, // port b enables
  input wire logic [7:0] port_d_pins_oe // port d enables
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_acc;
    psel && penable && pready;
  endsequence
  sequence s_wr(logic [11:0] a);
    s_acc ##0 pwrite && paddr == a;
  endsequence
  property p_dir; s_wr(12'h010) |=> port_a_pins_oe == $past(pwdata[7:0]); endproperty
  a_dir: assert property (p_dir) else $error("direction write not on enables");
  property p_dat; s_wr(12'h000) |=> port_a_pins_out == $past(pwdata[7:0]); endproperty
  a_dat: assert property (p_dat) else $error("latch write not on drive");
  property p_srst; $fell(srst) |-> (port_a_pins_oe | port_b_pins_oe | port_d_pins_oe) == 8'h00;
  endproperty
  a_srst: assert property (p_srst) else $error("enables set after reset");
  property p_rstn; !reset_n |=> port_a_pins_oe == 8'h00; endproperty
  a_rstn: assert property (p_rstn) else $error("enables set after reset pin");
  property p_bm; port_b_pins_oe[4:0] == 5'h00; endproperty
  a_bm: assert property (p_bm) else $error("port b low enable set");
  property p_dm; (port_d_pins_oe & 8'hdf) == 8'h00; endproperty
  a_dm: assert property (p_dm) else $error("port d extra enable set");
  property p_op; !$past(srst) |-> pready != $past(pready); endproperty
  a_op: assert property (p_op) else $error("ready not at half rate");
  property p_rd;
    s_acc ##0 !pwrite && paddr == 12'h000 && port_a_pins_oe == 8'hff |-> prdata[7:0] == port_a_pins_out;
  endproperty
  a_rd: assert property (p_rd) else $error("output read not latch");
endmodule
bind pio_top pio_chk i_chk(.clk, .srst, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pready, .prdata, .port_a_pins_out, .port_a_pins_oe, .port_b_pins_oe, .port_d_pins_oe);
`default_nettype wire

// file: testbench/pio_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module pio_top_tb;
  logic clk = 0, srst = 1, reset_n = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [7:0] pin[4] = '{default: 8'h00}, lat[4], e;
  logic [7:0] dm[4] = '{8'hff, 8'he0, 8'hff, 8'ha0}, dd[4] = '{8'hff, 8'he0, 8'hff, 8'h20};
  logic [8:0] expq[$], exp_rd;
  wire pready, pslverr, spe;
  wire [31:0] prdata;
  wire [7:0] oe[4], po[4];
  int num_errors = 0, samples_checked = 0, i, j;
  always #5 clk = ~clk;
  pio_top i_dut(.clk(clk), .srst(srst), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .port_a_pins_in(pin[0]), .port_a_pins_out(po[0]), .port_a_pins_oe(oe[0]),
    .port_b_pins_in(pin[1]), .port_b_pins_out(po[1]), .port_b_pins_oe(oe[1]),
    .port_c_pins_in(pin[2]), .port_c_pins_out(po[2]), .port_c_pins_oe(oe[2]),
    .port_d_pins_in(pin[3]), .port_d_pins_out(po[3]), .port_d_pins_oe(oe[3]), .serial_port_en(spe));
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ----------------------------------------
  // apb master
  // ----------------------------------------
  task automatic apb(logic w, logic [11:0] a, logic [7:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      num_errors++;
      finish_test;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(logic [11:0] a, logic [7:0] x, logic f = 1'b0);
    expq.push_back({f, x});
    apb(1'b0, a, 8'h00);
  endtask
  // ----------------------------------------
  // read monitor
  // ----------------------------------------
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      exp_rd = expq.pop_front();
      chk("prdata", prdata, {24'h000000, exp_rd[7:0]});
      chk("pslverr", pslverr, exp_rd[8]);
    end
  end
  initial begin
    i = $urandom(32'h3ac6a56e);
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    for (i = 0; i < 4; i++) chk("oe", oe[i], 8'h00);
    for (i = 0; i < 4; i++) begin
      lat[i] = 8'($urandom);
      pin[i] <= 8'($urandom);
      apb(1'b1, 12'(i * 4), lat[i]);
      rd(12'(i * 4), pin[i] & dm[i]);
      e = 8'($urandom);
      e = e & dd[i];
      apb(1'b1, 12'(i * 4 + 16), e);
      chk("oe", oe[i], e);
      chk("out", po[i] & oe[i], lat[i] & e);
      rd(12'(i * 4), ((lat[i] & e) | (pin[i] & ~e)) & dm[i]);
    end
    for (j = 0; j < 2; j++) begin
      apb(1'b1, 12'h010, 8'hff);
      if (j == 1) srst <= 1'b1;
      else reset_n <= 1'b0;
      @(posedge clk);
      srst <= 1'b0;
      reset_n <= 1'b1;
      @(posedge clk);
      chk("oe", oe[0], 8'h00);
      apb(1'b1, 12'h010, 8'hff);
      rd(12'h000, lat[0]);
    end
    rd(12'h024, 8'h00, 1'b1);
    apb(1'b1, 12'h014, 8'he0);
    chk("oe", oe[1], 8'he0);
    apb(1'b1, 12'h020, 8'h01);
    chk("spe", spe, 1'b1);
    chk("queue", expq.size(), 0);
    finish_test;
  end
endmodule
`default_nettype wire
